// file: design/eprom_boot_dma_loader.sv
`timescale 1ns/1ns
`default_nettype none

// Word buffer between packer and internal memory
module edbl_fifo #(
  parameter int WIDTH = 67,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage, flops
  logic [AW:0] wr_ptr; // Extra bit tells full from empty
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;
  // Honest flags from pointer compare
  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) ||
                    (wr_ptr[AW] == rd_ptr[AW]);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Data array needs no reset; valid guards it
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// Summary of operation
// - EPROM mode from straps; select becomes output
// - Pack EPROM bytes into 48-bit words
// - Fill 256 words at 0x40000..0x400FF, then run
// - Boot bytes on lanes 23:16, 8M space
// - Only bus master drives boot select
// - Up to six devices share one EPROM
// - Reset wait config: async, seven wait states
// - Word counter resets to 0x100
// - Byte counter resets to 0x600
// - Control word resets to 0x561
// - Indexes start 0x40000, 0x800000, step one
// - After reset idle with PC 0x40004
// - Read strobe held eight cycles per byte
// - Other memory selects off during boot
// - Counters hit zero: stop, interrupt, vector
// - Return from vector resumes at 0x40005
// - Channel runs on port buffer zero
module eprom_boot_dma_loader
  (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Boot straps
  input wire logic external_boot_pin,
  input wire logic link_boot_pin,
  // Bus arbitration
  input wire logic bus_master,
  // External port towards the EPROM
  output logic [23:0] external_address_bus,
  output logic external_address_oe,
  output logic read_strobe_n,
  output logic read_strobe_oe,
  output logic boot_select_n,
  output logic boot_select_oe,
  input wire logic [edbl_pkg::EDBL_DATA_W-1:0] data_bus_in,
  // Ordinary memory selects
  input wire logic [edbl_pkg::EDBL_SEL_W-1:0] normal_select_n,
  output logic [edbl_pkg::EDBL_SEL_W-1:0] memory_select_n,
  // Internal memory write port
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output edbl_pkg::edbl_mem_wr_t mem_wr,
  // Core sequencing
  input wire logic return_from_interrupt,
  output logic core_idle,
  output logic [23:0] program_counter,
  output logic boot_channel_interrupt,
  // Configuration and status
  output logic [31:0] boot_dma_control,
  output logic [2:0] boot_wait_state_field,
  output logic boot_access_mode_field,
  output logic eprom_boot_mode,
  output logic boot_done
);
  import edbl_pkg::*;
  edbl_state_t state; // Loader sequence
  edbl_state_t next_state;
  logic [2:0] wait_cnt; // Strobe cycles left
  logic [2:0] next_wait_cnt;
  logic [2:0] byte_sel; // Byte position in word
  logic [2:0] next_byte_sel;
  logic [2:0] lane; // Byte lane chosen by word order
  logic [8:0] internal_word_count;
  logic [8:0] next_internal_word_count;
  logic [10:0] external_byte_count;
  logic [10:0] next_external_byte_count;
  logic [18:0] internal_index;
  logic [18:0] next_internal_index;
  logic [23:0] external_index;
  logic [23:0] next_external_index;
  logic [47:0] pack; // Word being assembled
  logic [47:0] next_pack;
  logic [23:0] next_program_counter;
  logic [23:0] next_external_address_bus;
  logic [31:0] next_boot_dma_control;
  logic [2:0] next_boot_wait_state_field;
  logic next_boot_access_mode_field;
  logic next_eprom_boot_mode;
  logic next_boot_done;
  logic next_core_idle;
  logic next_read_strobe_n;
  logic next_boot_select_n;
  logic next_irq;
  logic [EDBL_SEL_W-1:0] next_memory_select_n;
  logic [7:0] boot_byte_lane; // Byte sampled from the EPROM
  logic channel_enable_field;
  logic word_order_field;
  logic data_type_field;
  logic master_mode_field;
  logic [2:0] pack_mode_field;
  logic channel_go; // Control word allows this transfer
  logic fifo_in_ready;
  edbl_mem_wr_t fifo_in;
  logic fifo_in_valid;
  logic driving; // Master and still booting

  // Control word fields steer the channel
  assign channel_enable_field = boot_dma_control[EDBL_DEN_BIT];
  assign word_order_field = boot_dma_control[EDBL_WORD_ORDER_FIELD_BIT];
  assign data_type_field = boot_dma_control[EDBL_DATA_TYPE_FIELD_BIT];
  assign master_mode_field = boot_dma_control[EDBL_MASTER_BIT];
  assign pack_mode_field = boot_dma_control[EDBL_PACK_MODE_FIELD_LSB +: 3];
  assign channel_go = channel_enable_field && master_mode_field &&
                      data_type_field &&
                      (pack_mode_field == EDBL_PACK_MODE_FIELD_8_48);
  // Lane 23:16 only carries boot data
  assign boot_byte_lane = data_bus_in[EDBL_LANE_LSB +: 8];
  // Lowest byte first unless the order field flips it
  assign lane = word_order_field ? (EDBL_LAST_BYTE - byte_sel)
                                 : byte_sel;
  // Pins are driven only while this device is bus master
  assign driving = eprom_boot_mode && !boot_done && bus_master;
  assign boot_select_oe = driving;
  assign external_address_oe = driving;
  assign read_strobe_oe = driving;

  // Completed word goes to the buffer on port buffer zero
  assign fifo_in_valid = (state == EDBL_ST_PUSH);
  assign fifo_in = '{addr: internal_index, data: pack};

  // Loader next-state logic
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_byte_sel = byte_sel;
    next_internal_word_count = internal_word_count;
    next_external_byte_count = external_byte_count;
    next_internal_index = internal_index;
    next_external_index = external_index;
    next_pack = pack;
    next_program_counter = program_counter;
    next_external_address_bus = external_address_bus;
    next_boot_dma_control = boot_dma_control;
    next_boot_wait_state_field = boot_wait_state_field;
    next_boot_access_mode_field = boot_access_mode_field;
    next_eprom_boot_mode = eprom_boot_mode;
    next_boot_done = boot_done;
    next_core_idle = core_idle;
    next_read_strobe_n = 1'b1;
    next_boot_select_n = 1'b1;
    next_irq = 1'b0;
    next_memory_select_n = memory_select_n;
    case (state)
      // Straps are caught on the first edge after release
      EDBL_ST_STRAP: begin
        next_eprom_boot_mode = external_boot_pin && !link_boot_pin;
        next_state = EDBL_ST_INIT;
      end
      // Channel parameters take their boot values
      EDBL_ST_INIT: begin
        next_program_counter = EDBL_PC_IDLE;
        next_core_idle = 1'b1;
        next_boot_dma_control = EDBL_DMA_CTRL_RST;
        next_internal_word_count = EDBL_WORD_CNT_RST;
        next_external_byte_count = EDBL_BYTE_CNT_RST;
        next_internal_index = EDBL_INT_BASE;
        next_external_index = EDBL_EXT_BASE;
        next_boot_wait_state_field = EDBL_BOOT_WS_RST;
        next_boot_access_mode_field = EDBL_BOOT_AM_ASYNC;
        next_byte_sel = 3'h0;
        next_pack = '0;
        if (eprom_boot_mode) begin
          next_state = EDBL_ST_ARB;
        end else begin
          // Other boot modes live elsewhere
          next_state = EDBL_ST_OTHER;
        end
      end
      // Wait for bus ownership before each byte
      EDBL_ST_ARB: begin
        if (bus_master && channel_go) begin
          next_boot_select_n = 1'b0;
          next_read_strobe_n = 1'b0;
          next_external_address_bus = external_index;
          next_wait_cnt = boot_wait_state_field;
          next_state = EDBL_ST_READ;
        end
      end
      // Strobe held for wait states plus one cycle
      EDBL_ST_READ: begin
        if (wait_cnt == 3'h0) begin
          next_pack[{lane, 3'b000} +: 8] = boot_byte_lane;
          next_external_index = external_index + EDBL_EXT_MOD;
          next_external_byte_count = external_byte_count - 11'h001;
          if (byte_sel == EDBL_LAST_BYTE) begin
            next_byte_sel = 3'h0;
            next_state = EDBL_ST_PUSH;
          end else begin
            next_byte_sel = byte_sel + 3'h1;
            next_state = EDBL_ST_ARB;
          end
        end else begin
          next_boot_select_n = 1'b0;
          next_read_strobe_n = 1'b0;
          next_wait_cnt = wait_cnt - 3'h1;
        end
      end
      // Hand word to the buffer; stall while it is full
      EDBL_ST_PUSH: begin
        if (fifo_in_ready) begin
          next_internal_index = internal_index + EDBL_INT_MOD;
          next_internal_word_count = internal_word_count - 9'h001;
          next_pack = '0;
          if ((internal_word_count == 9'h001) &&
              (external_byte_count == 11'h000)) begin
            next_state = EDBL_ST_DRAIN;
          end else begin
            next_state = EDBL_ST_ARB;
          end
        end
      end
      // Last word must reach memory before waking
      EDBL_ST_DRAIN: begin
        if (!mem_wr_valid) begin
          next_irq = 1'b1;
          next_boot_done = 1'b1;
          next_memory_select_n = normal_select_n;
          next_program_counter = EDBL_PC_VECTOR;
          next_core_idle = 1'b0;
          next_state = EDBL_ST_RUN;
        end
      end
      // Normal execution; selects follow the core
      EDBL_ST_RUN: begin
        next_memory_select_n = normal_select_n;
        if (return_from_interrupt) begin
          next_program_counter = EDBL_PC_RESUME;
        end
      end
      // Non-EPROM mode: stay idle, pins released
      EDBL_ST_OTHER: begin
        next_state = EDBL_ST_OTHER;
      end
      default: begin
        next_state = EDBL_ST_STRAP;
      end
    endcase
  end

  // Loader registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= EDBL_ST_STRAP;
      wait_cnt <= 3'h0;
      byte_sel <= 3'h0;
      internal_word_count <= EDBL_WORD_CNT_RST;
      external_byte_count <= EDBL_BYTE_CNT_RST;
      internal_index <= EDBL_INT_BASE;
      external_index <= EDBL_EXT_BASE;
      pack <= '0;
      program_counter <= EDBL_PC_IDLE;
      external_address_bus <= EDBL_EXT_BASE;
      boot_dma_control <= EDBL_DMA_CTRL_RST;
      boot_wait_state_field <= EDBL_BOOT_WS_RST;
      boot_access_mode_field <= EDBL_BOOT_AM_ASYNC;
      eprom_boot_mode <= 1'b0;
      boot_done <= 1'b0;
      core_idle <= 1'b1;
      read_strobe_n <= 1'b1;
      boot_select_n <= 1'b1;
      boot_channel_interrupt <= 1'b0;
      memory_select_n <= '1;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      byte_sel <= next_byte_sel;
      internal_word_count <= next_internal_word_count;
      external_byte_count <= next_external_byte_count;
      internal_index <= next_internal_index;
      external_index <= next_external_index;
      pack <= next_pack;
      program_counter <= next_program_counter;
      external_address_bus <= next_external_address_bus;
      boot_dma_control <= next_boot_dma_control;
      boot_wait_state_field <= next_boot_wait_state_field;
      boot_access_mode_field <= next_boot_access_mode_field;
      eprom_boot_mode <= next_eprom_boot_mode;
      boot_done <= next_boot_done;
      core_idle <= next_core_idle;
      read_strobe_n <= next_read_strobe_n;
      boot_select_n <= next_boot_select_n;
      boot_channel_interrupt <= next_irq;
      memory_select_n <= next_memory_select_n;
    end
  end

  // Buffer decouples EPROM reads from memory stalls
  edbl_fifo #(
    .WIDTH($bits(edbl_mem_wr_t)),
    .DEPTH(EDBL_FIFO_DEPTH)
  ) u_word_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr)
  );
endmodule

`default_nettype wire

// file: design/edbl_pkg.sv
package edbl_pkg;
  // Widths of the boot path
  localparam int EDBL_DATA_W = 32;
  localparam int EDBL_WORD_W = 48;
  localparam int EDBL_IADDR_W = 19;
  localparam int EDBL_EADDR_W = 24;
  localparam int EDBL_SEL_W = 4;
  localparam int EDBL_FIFO_DEPTH = 32;
  // Boot byte travels on data lanes 23:16
  localparam int EDBL_LANE_LSB = 16;
  localparam logic [2:0] EDBL_LAST_BYTE = 3'h5;
  // Internal memory, EPROM and program counter addresses
  localparam logic [18:0] EDBL_INT_BASE = 19'h40000;
  localparam logic [18:0] EDBL_INT_MOD = 19'h00001;
  localparam logic [23:0] EDBL_EXT_BASE = 24'h800000;
  localparam logic [23:0] EDBL_EXT_MOD = 24'h000001;
  localparam logic [23:0] EDBL_PC_IDLE = 24'h040004;
  localparam logic [23:0] EDBL_PC_VECTOR = 24'h040050;
  localparam logic [23:0] EDBL_PC_RESUME = 24'h040005;
  // Counter reset values
  localparam logic [8:0] EDBL_WORD_CNT_RST = 9'h100;
  localparam logic [10:0] EDBL_BYTE_CNT_RST = 11'h600;
  // Channel control word and its fields
  localparam logic [31:0] EDBL_DMA_CTRL_RST = 32'h00000561;
  localparam int EDBL_DEN_BIT = 0;
  localparam int EDBL_WORD_ORDER_FIELD_BIT = 1;
  localparam int EDBL_DATA_TYPE_FIELD_BIT = 5;
  localparam int EDBL_PACK_MODE_FIELD_LSB = 6;
  localparam int EDBL_MASTER_BIT = 10;
  localparam logic [2:0] EDBL_PACK_MODE_FIELD_8_48 = 3'h5;
  // Boot memory wait configuration
  localparam logic [2:0] EDBL_BOOT_WS_RST = 3'h7;
  localparam logic EDBL_BOOT_AM_ASYNC = 1'b0;

  // Loader sequence
  typedef enum logic [2:0] {
    EDBL_ST_STRAP = 3'b000,
    EDBL_ST_INIT = 3'b001,
    EDBL_ST_ARB = 3'b010,
    EDBL_ST_READ = 3'b011,
    EDBL_ST_PUSH = 3'b100,
    EDBL_ST_DRAIN = 3'b101,
    EDBL_ST_RUN = 3'b110,
    EDBL_ST_OTHER = 3'b111
  } edbl_state_t;

  // One internal memory write
  typedef struct packed {
    logic [18:0] addr;
    logic [47:0] data;
  } edbl_mem_wr_t;
endpackage

// file: test/edbl_props.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the boot loader
module edbl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // External port
  input wire logic bus_master,
  input wire logic [23:0] external_address_bus,
  input wire logic read_strobe_n,
  input wire logic boot_select_n,
  input wire logic boot_select_oe,
  input wire logic [3:0] normal_select_n,
  input wire logic [3:0] memory_select_n,
  // Internal memory writes
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire edbl_pkg::edbl_mem_wr_t mem_wr,
  // Core and status
  input wire logic return_from_interrupt,
  input wire logic core_idle,
  input wire logic [23:0] program_counter,
  input wire logic boot_channel_interrupt,
  input wire logic [31:0] boot_dma_control,
  input wire logic eprom_boot_mode,
  input wire logic boot_done
);
  import edbl_pkg::*;
  logic [23:0] exp_addr; // Next EPROM byte address
  logic [23:0] next_exp_addr;
  logic [18:0] exp_waddr; // Next internal word address
  logic [18:0] next_exp_waddr;
  logic prev_rd_n; // Strobe one cycle back
  // Address streams advance on strobe fall and on each write taken
  always_comb begin
    next_exp_addr = exp_addr;
    next_exp_waddr = exp_waddr;
    if (prev_rd_n && !read_strobe_n) next_exp_addr = exp_addr + 24'h1;
    if (mem_wr_valid && mem_wr_ready) next_exp_waddr = exp_waddr + 19'h1;
  end
  // Registers only; a reset restarts both streams at their bases
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exp_addr <= EDBL_EXT_BASE;
      exp_waddr <= EDBL_INT_BASE;
      prev_rd_n <= 1'b1;
    end else begin
      exp_addr <= next_exp_addr;
      exp_waddr <= next_exp_waddr;
      prev_rd_n <= read_strobe_n;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  strobe_pair_a: assert property (read_strobe_n == boot_select_n)
    else $error("strobe and select differ");
  strobe_len_a: assert property ($fell(read_strobe_n) |->
    (!read_strobe_n)[*8] ##1 read_strobe_n) else $error("bad strobe length");
  addr_hold_a: assert property ($fell(read_strobe_n) |->
    ##1 $stable(external_address_bus)[*7]) else $error("address moved");
  addr_order_a: assert property ($fell(read_strobe_n) |->
    external_address_bus == exp_addr) else $error("wrong byte address");
  word_addr_a: assert property (mem_wr_valid |->
    mem_wr.addr == exp_waddr) else $error("wrong word address");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr)) else $error("stalled word changed");
  master_only_a: assert property (boot_select_oe |->
    bus_master && eprom_boot_mode && !boot_done) else $error("select driven");
  sel_off_a: assert property (!boot_done |-> memory_select_n == 4'hf)
    else $error("memory select active in boot");
  sel_restore_a: assert property (boot_done && $past(boot_done) |->
    memory_select_n == $past(normal_select_n)) else $error("select lost");
  wake_seq_a: assert property ($rose(boot_done) |->
    boot_channel_interrupt && !core_idle && exp_waddr == 19'h40100 &&
    program_counter == EDBL_PC_VECTOR ##1 !boot_channel_interrupt)
    else $error("bad wake sequence");
  idle_pc_a: assert property (!boot_done |->
    core_idle && program_counter == EDBL_PC_IDLE) else $error("not idle");
  resume_a: assert property (boot_done && return_from_interrupt |=>
    program_counter == EDBL_PC_RESUME) else $error("bad resume address");
  ctrl_word_a: assert property (boot_dma_control == 32'h561)
    else $error("bad control word");
endmodule
bind eprom_boot_dma_loader edbl_props u_props (.clk, .sys_rst, .bus_master,
  .external_address_bus, .read_strobe_n, .boot_select_n, .boot_select_oe,
  .normal_select_n, .memory_select_n, .mem_wr_valid, .mem_wr_ready, .mem_wr,
  .return_from_interrupt, .core_idle, .program_counter,
  .boot_channel_interrupt, .boot_dma_control, .eprom_boot_mode, .boot_done);
`default_nettype wire

// file: test/edbl_eprom_model.sv
`timescale 1ns/1ns
`default_nettype none
// Byte-wide asynchronous boot EPROM
module edbl_eprom_model #(
  parameter int ACCESS = 3 // Cycles from select to valid data
) (
  // Clock
  input wire logic clk,
  // Pins from the loader
  input wire logic [23:0] external_address_bus,
  input wire logic read_strobe_n,
  input wire logic boot_select_n,
  input wire logic drive_en,
  // Data bus back to the loader
  output logic [31:0] data_bus
);
  logic [3:0] age; // Cycles selected, saturating
  logic [31:0] junk = 32'h0; // Changes every cycle
  // Select as chip enable, strobe as output enable
  wire logic on = !boot_select_n && !read_strobe_n && drive_en;
  // Access timer; released bus never holds the old byte
  always @(posedge clk) begin
    junk <= ~junk + 32'h1357;
    age <= on ? age + 4'(age != 4'hf) : 4'h0;
  end
  // Byte on lanes 23:16 only, from the low address lines
  assign data_bus = (on && age >= ACCESS) ? {junk[31:24],
    external_address_bus[7:0] ^ external_address_bus[15:8] ^ 8'h3c,
    junk[15:0]} : junk;
endmodule
`default_nettype wire

// file: test/tb_eprom_boot_dma_loader.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the boot loader
module tb_eprom_boot_dma_loader;
  import edbl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst, external_boot_pin, link_boot_pin, bus_master;
  logic [23:0] external_address_bus, program_counter;
  logic read_strobe_n, read_strobe_oe, boot_select_n, boot_select_oe;
  logic [31:0] data_bus_in, boot_dma_control, rng;
  logic [3:0] normal_select_n, memory_select_n;
  logic mem_wr_valid, mem_wr_ready, return_from_interrupt, core_idle;
  edbl_mem_wr_t mem_wr;
  logic boot_channel_interrupt, boot_access_mode_field;
  logic [2:0] boot_wait_state_field;
  logic eprom_boot_mode, boot_done, stall, any_oe, wake_idle;
  logic prev_rd = 1'b1; // Strobe at the last falling edge
  logic [23:0] wake_pc; // Program counter seen with the interrupt
  int fail_count, compares, cyc, falls, words, irqs, f0, n;
  eprom_boot_dma_loader dut (.clk, .sys_rst, .external_boot_pin,
    .link_boot_pin, .bus_master, .external_address_bus,
    .external_address_oe(), .read_strobe_n, .read_strobe_oe,
    .boot_select_n, .boot_select_oe, .data_bus_in, .normal_select_n,
    .memory_select_n, .mem_wr_valid, .mem_wr_ready, .mem_wr,
    .return_from_interrupt, .core_idle, .program_counter,
    .boot_channel_interrupt, .boot_dma_control, .boot_wait_state_field,
    .boot_access_mode_field, .eprom_boot_mode, .boot_done);
  // Slow part: data only valid late in the strobe
  edbl_eprom_model #(.ACCESS(6)) u_rom (.clk, .external_address_bus,
    .read_strobe_n, .boot_select_n, .data_bus(data_bus_in),
    .drive_en(boot_select_oe & read_strobe_oe));
  initial forever #20 clk = ~clk;
  // Ceiling well above the roughly 20k cycles a clean run needs
  initial begin
    wait (cyc > 60000);
    fail_count++;
    wrap_up();
  end
  // Seeded xorshift for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Word k: six bytes, first byte in the low lane
  function automatic logic [47:0] exp_word(input int k);
    logic [47:0] w;
    logic [23:0] a;
    for (int i = 0; i < 6; i++) begin
      a = 24'h800000 + 24'(6 * k + i);
      w[8*i +: 8] = a[7:0] ^ a[15:8] ^ 8'h3c;
    end
    return w;
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset held 20 cycles with the given straps
  task automatic do_reset(input logic eb, input logic lb);
    sys_rst = 1'b1;
    external_boot_pin = eb;
    link_boot_pin = lb;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    any_oe = 1'b0;
  endtask
  // Falling-edge driver and monitor
  always @(negedge clk) begin
    cyc++;
    // Shared EPROM: a device off the bus leaves the select alone
    if (!sys_rst && !bus_master) check(48'(boot_select_oe), 48'h0);
    rng = xs(rng);
    mem_wr_ready = !stall && rng[0];
    // Bus ownership only moves between reads
    if (read_strobe_n) bus_master = rng[1] | rng[2];
    if (!sys_rst) begin
      if (prev_rd && !read_strobe_n) falls++;
      any_oe = any_oe | boot_select_oe;
      if (boot_channel_interrupt) begin
        irqs++;
        wake_pc = program_counter;
        wake_idle = core_idle;
      end
      // Handshake completes at the coming rising edge
      if (mem_wr_valid && mem_wr_ready) begin
        check(mem_wr.data, exp_word(words));
        check(48'(mem_wr.addr), 48'(19'h40000 + 19'(words)));
        words++;
      end
    end
    prev_rd = read_strobe_n;
  end
  initial begin
    rng = 32'd85685;
    stall = 1'b1;
    bus_master = 1'b0;
    mem_wr_ready = 1'b0;
    normal_select_n = 4'h5;
    return_from_interrupt = 1'b0;
    // Straps other than EPROM boot leave the pins released
    for (int s = 0; s < 3; s++) begin
      do_reset(s == 2, s != 0);
      repeat (100) @(negedge clk);
      check(48'(eprom_boot_mode), 48'h0);
      check(48'(any_oe), 48'h0);
    end
    $display("strap test done");
    do_reset(1'b1, 1'b0);
    // Straps are taken at the first edge after release
    repeat (2) @(negedge clk);
    check(48'(boot_dma_control), 48'h561);
    check(48'(boot_wait_state_field), 48'h7);
    check(48'(boot_access_mode_field), 48'h0);
    check(48'(program_counter), 48'h40004);
    check(48'(memory_select_n), 48'hf);
    check(48'(eprom_boot_mode), 48'h1);
    // Memory stalls: buffer fills and reads must stop
    repeat (4000) @(negedge clk);
    f0 = falls;
    repeat (300) @(negedge clk);
    check(48'(falls), 48'(f0));
    check(48'(falls >= 192), 48'h1);
    check(48'(words), 48'h0);
    check(48'(any_oe), 48'h1);
    $display("stall test done");
    stall = 1'b0;
    n = 0;
    while (!boot_done && n < 50000) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    check(48'(words), 48'd256);
    check(48'(falls), 48'd1536);
    check(48'(irqs), 48'd1);
    check(48'(wake_pc), 48'h40050);
    check(48'(wake_idle), 48'h0);
    check(48'(boot_select_oe), 48'h0);
    // Low bit clear: never the boot-time value nor all ones
    normal_select_n = {rng[7:5], 1'b0};
    repeat (2) @(negedge clk);
    check(48'(memory_select_n), 48'(normal_select_n));
    return_from_interrupt = 1'b1;
    @(negedge clk);
    return_from_interrupt = 1'b0;
    check(48'(program_counter), 48'h40005);
    $display("boot test done");
    wrap_up();
  end
endmodule
`default_nettype wire
